// [cal_pkg.sv]
// Shared constants and types for the calculator sequencer
package cal_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned DIGIT_TIME_NS = 58_000;
  localparam int unsigned BLANK_TIME_NS = 14_500;
  localparam int unsigned DIGIT_CYC = (DIGIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned KEY_WORDS = 11;
  localparam int unsigned CALC_WORDS_MAX = 200;
  localparam int unsigned NUM_DIGITS = 8;
  localparam int unsigned DISP_POS = 9;
  localparam logic [3:0] LAST_POS = 4'h8;
  localparam logic [4:0] DP_MAX = 5'h08;
  localparam logic [4:0] PCT_SHIFT = 5'h02;
  localparam logic [4:0] DIV_EXTRA = 5'h0A;
  localparam logic [63:0] MAX_MAG = 64'h0000_0000_05F5_E0FF;
  localparam logic [7:0] SEG_MINUS = 8'h40;
  localparam logic [7:0] SEG_DP = 8'h80;

  typedef struct packed {
    logic neg;
    logic [3:0] dp;
    logic [31:0] dig;
  } cal_num_t;

  typedef enum logic [1:0] {CM_ADD, CM_SUB, CM_MUL, CM_DIV} cal_mode_t;

  typedef enum logic [3:0] {
    CK_NONE, CK_DIGIT, CK_POINT, CK_SIGN, CK_PLUS, CK_MINUS, CK_MUL, CK_DIV,
    CK_EQ, CK_PCT, CK_CLEAR, CK_MSAVE, CK_MRECALL, CK_MPLUS, CK_MMINUS
  } cal_fn_t;

  typedef struct packed {
    cal_fn_t fn;
    logic [3:0] val;
  } cal_key_t;

  typedef enum logic [1:0] {SQ_IDLE, SQ_DIVIDE, SQ_NORM} cal_seq_t;
  typedef enum logic [1:0] {DB_SCAN, DB_PRESS, DB_HELD} cal_db_t;

  typedef struct packed {
    logic key_return_one;
    logic key_return_two;
    logic key_return_three;
    logic key_return_four;
  } cal_ret_t;
endpackage : cal_pkg

// [cal_core.sv]
// Calculator sequencer: key scan, debounce, four registers, one-cycle add/subtract/multiply with serial divide, display mux
`timescale 1ns/1ps
// Contract
// - Three BCD registers, eight digits, sign, point; working register binary
// - Entry register always displayed, takes results
// - Accumulator copies results for chaining
// - Working register holds product or dividend
// - Memory changes only on save, plus, minus
// - Power-on clears all registers including memory
// - Do pending mode operation, then load mode
// - Terminate set: arithmetic key starts new problem
// - Arithmetic keys clear terminate flag
// - Equals, sometimes percent or clear, set terminate
// - Constant add/subtract on equals, accumulator kept
// - Chained add/subtract updates entry and accumulator
// - No new number: arithmetic key changes mode
// - Equals saves displayed number as constant
// - Percent multiplies accumulator by entry over 100
// - Percent shifts point, copies, selects multiply
// - Constant multiply on repeated equals
// - Constant is the last number entered
// - Ninth digit shows memory, sign or error point only
// - Blank leading zeros, floating minus sign
// - Any calculation ends within 200 word times
// - Power-on selects add, sets terminate flag
// - Eleven word debounce on press and release
// - Overflow beyond eight digits sets error display
// - Ninth and later keyed digits are ignored
module cal_core #(
  parameter int unsigned DIGIT_CYC = cal_pkg::DIGIT_CYC,
  parameter int unsigned BLANK_CYC = cal_pkg::BLANK_CYC,
  parameter int unsigned KEY_WORDS = cal_pkg::KEY_WORDS
) (
  input wire logic i_ref_clk, // 25 MHz clock
  input wire logic i_resetn, // Power-on clear, active low
  input wire logic i_key_return_one, // Key matrix return 1
  input wire logic i_key_return_two, // Key matrix return 2
  input wire logic i_key_return_three, // Key matrix return 3
  input wire logic i_key_return_four, // Key matrix return 4
  output logic [8:0] o_digit_strobe, // Bit 0 rightmost, bit 8 leftmost
  output logic [7:0] o_segment, // Bits 6:0 g..a, bit 7 point
  output logic o_error, // Error condition held
  output logic o_busy // Calculation in progress
);
  // A one-word debounce would skip the press count that raises fire
  if (DIGIT_CYC < 2 || DIGIT_CYC > 2047 || BLANK_CYC >= DIGIT_CYC || KEY_WORDS < 2 || KEY_WORDS > 15) begin : g_chk
    $error("cal_core: unsupported timing parameters");
  end

  typedef struct packed {
    cal_pkg::cal_seq_t seq;
    cal_pkg::cal_num_t ent;
    cal_pkg::cal_num_t acc;
    cal_pkg::cal_num_t mem;
    cal_pkg::cal_mode_t mode;
    logic term;
    logic entry_on;
    logic entered;
    logic pt;
    logic err;
    logic [63:0] wrk;
    logic [26:0] den;
    logic [27:0] rem;
    logic [5:0] cnt;
    logic [4:0] rdp;
    logic rneg;
    logic wb_acc;
    logic wb_mem;
    logic [10:0] tick;
    logic [3:0] pos;
    logic seen;
    cal_pkg::cal_key_t seen_key;
    cal_pkg::cal_db_t db;
    logic [3:0] db_cnt;
    cal_pkg::cal_key_t db_key;
    logic [8:0] strobe;
    logic [7:0] seg;
    logic busy;
  } cal_state_t;

  cal_state_t st_r;
  cal_state_t st_nxt;
  logic [1:0] rst_sync_r;
  logic rst_q;
  cal_pkg::cal_ret_t ret;
  logic fire;
  logic go;
  logic xdp2;
  logic ydp2;
  cal_pkg::cal_mode_t op;
  cal_pkg::cal_mode_t kmode;
  cal_pkg::cal_num_t opx;
  cal_pkg::cal_num_t opy;
  cal_pkg::cal_num_t res;
  logic [63:0] bx;
  logic [63:0] by;
  logic [4:0] dx;
  logic [4:0] dy;
  logic [4:0] dm;
  logic signed [65:0] sx;
  logic signed [65:0] sy;
  logic signed [65:0] sum;
  logic [28:0] trial;
  logic [3:0] top;
  logic [3:0] dval;

  function automatic logic [63:0] cal_bcd2bin(input logic [31:0] d);
    logic [63:0] v;
    v = '0;
    for (int i = 7; i >= 0; i--) begin
      v = (v << 3) + (v << 1) + 64'(d[4*i+:4]);
    end
    return v;
  endfunction : cal_bcd2bin

  function automatic logic [31:0] cal_bin2bcd(input logic [26:0] b);
    logic [31:0] d;
    d = '0;
    for (int i = 26; i >= 0; i--) begin
      for (int j = 0; j < 8; j++) begin
        if (d[4*j+:4] > 4'h4) begin
          d[4*j+:4] = d[4*j+:4] + 4'h3;
        end
      end
      d = {d[30:0], b[i]};
    end
    return d;
  endfunction : cal_bin2bcd

  function automatic logic [63:0] cal_pow10(input logic [4:0] n);
    logic [63:0] v;
    v = 64'h1;
    for (int i = 0; i < 16; i++) begin
      if (5'(i) < n) begin
        v = (v << 3) + (v << 1);
      end
    end
    return v;
  endfunction : cal_pow10

  // Highest position that must be lit: top nonzero digit or the point
  function automatic logic [3:0] cal_top(input cal_pkg::cal_num_t n);
    logic [3:0] t;
    t = n.dp;
    for (int i = 0; i < 8; i++) begin
      if (n.dig[4*i+:4] != 4'h0 && 4'(i) > t) begin
        t = 4'(i);
      end
    end
    return t;
  endfunction : cal_top

  function automatic logic [7:0] cal_seven(input logic [3:0] d);
    logic [7:0] s;
    unique case (d)
      4'h0: s = 8'h3F;
      4'h1: s = 8'h06;
      4'h2: s = 8'h5B;
      4'h3: s = 8'h4F;
      4'h4: s = 8'h66;
      4'h5: s = 8'h6D;
      4'h6: s = 8'h7D;
      4'h7: s = 8'h07;
      4'h8: s = 8'h7F;
      4'h9: s = 8'h6F;
      default: s = 8'h00;
    endcase
    return s;
  endfunction : cal_seven

  // Matrix position to key; lowest return wins when several are high
  function automatic cal_pkg::cal_key_t cal_key_map(input logic [3:0] p, input cal_pkg::cal_ret_t r);
    logic [5:0] c;
    cal_pkg::cal_key_t k;
    c = {p, r.key_return_one ? 2'h0 : r.key_return_two ? 2'h1 : r.key_return_three ? 2'h2 : 2'h3};
    k.val = c[3:0];
    k.fn = (c < 6'h0A) ? cal_pkg::CK_DIGIT : cal_pkg::CK_NONE;
    if (c >= 6'h0A && c <= 6'h16) begin
      k.fn = cal_pkg::cal_fn_t'(c[3:0] - 4'h8);
      if (c >= 6'h10) begin
        k.fn = cal_pkg::cal_fn_t'(c[3:0] + 4'h8);
      end
    end
    return k;
  endfunction : cal_key_map

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_r[1];
  assign ret = {i_key_return_one, i_key_return_two, i_key_return_three, i_key_return_four};

  always_comb begin
    st_nxt = st_r;
    fire = 1'b0;
    go = 1'b0;
    xdp2 = 1'b0;
    ydp2 = 1'b0;
    op = st_r.mode;
    opx = st_r.acc;
    opy = st_r.ent;
    bx = '0;
    by = '0;
    dx = '0;
    dy = '0;
    dm = '0;
    sx = '0;
    sy = '0;
    sum = '0;
    trial = '0;
    res = '0;
    kmode = cal_pkg::cal_mode_t'(st_r.db_key.fn[1:0]);
    // Scan: one digit position per digit time, returns sampled at its end
    st_nxt.tick = st_r.tick + 11'h1;
    if (st_r.tick == 11'(DIGIT_CYC - 1)) begin
      st_nxt.tick = '0;
      st_nxt.pos = (st_r.pos == cal_pkg::LAST_POS) ? 4'h0 : st_r.pos + 4'h1;
      if (ret != '0 && !st_r.seen) begin
        st_nxt.seen = 1'b1;
        st_nxt.seen_key = cal_key_map(st_r.pos, ret);
      end
    end
    // Word boundary: debounce on whole-word samples
    if (st_r.tick == 11'h0 && st_r.pos == 4'h0) begin
      st_nxt.seen = 1'b0;
      st_nxt.seen_key = '0;
      unique case (st_r.db)
        cal_pkg::DB_SCAN: begin
          if (st_r.seen) begin
            st_nxt.db = cal_pkg::DB_PRESS;
            st_nxt.db_key = st_r.seen_key;
            st_nxt.db_cnt = 4'h1;
          end
        end
        cal_pkg::DB_PRESS: begin
          if (st_r.seen && st_r.seen_key == st_r.db_key) begin
            st_nxt.db_cnt = st_r.db_cnt + 4'h1;
            if (st_r.db_cnt + 4'h1 == 4'(KEY_WORDS)) begin
              fire = (st_r.seq == cal_pkg::SQ_IDLE);
              st_nxt.db = cal_pkg::DB_HELD;
              st_nxt.db_cnt = 4'h0;
            end
          end else begin
            st_nxt.db = cal_pkg::DB_SCAN;
          end
        end
        default: begin
          st_nxt.db_cnt = st_r.seen ? 4'h0 : st_r.db_cnt + 4'h1;
          if (!st_r.seen && st_r.db_cnt + 4'h1 >= 4'(KEY_WORDS)) begin
            st_nxt.db = cal_pkg::DB_SCAN;
          end
        end
      endcase
    end
    if (fire) begin
      st_nxt.wb_acc = 1'b0;
      st_nxt.wb_mem = 1'b0;
      if (st_r.err) begin
        if (st_r.db_key.fn == cal_pkg::CK_CLEAR) begin
          st_nxt.err = 1'b0;
          st_nxt.ent = '0;
          st_nxt.acc = '0;
          st_nxt.mode = cal_pkg::CM_ADD;
          st_nxt.term = 1'b1;
        end
      end else begin
        if (st_r.db_key.fn != cal_pkg::CK_DIGIT && st_r.db_key.fn != cal_pkg::CK_POINT &&
            st_r.db_key.fn != cal_pkg::CK_SIGN) begin
          st_nxt.entry_on = 1'b0;
        end
        unique case (st_r.db_key.fn)
          cal_pkg::CK_DIGIT, cal_pkg::CK_POINT: begin
            if (!st_r.entry_on) begin
              st_nxt.ent = '0;
              st_nxt.entry_on = 1'b1;
              st_nxt.entered = 1'b1;
              st_nxt.pt = 1'b0;
            end
            if (st_r.db_key.fn == cal_pkg::CK_POINT) begin
              st_nxt.pt = 1'b1;
            end else if (!st_r.entry_on) begin
              st_nxt.ent.dig = {28'h0, st_r.db_key.val};
            end else if (st_r.ent.dig[31:28] == 4'h0) begin
              st_nxt.ent.dig = {st_r.ent.dig[27:0], st_r.db_key.val};
              st_nxt.ent.dp = st_r.ent.dp + {3'h0, st_r.pt};
            end
          end
          cal_pkg::CK_SIGN: st_nxt.ent.neg = ~st_r.ent.neg;
          cal_pkg::CK_PLUS, cal_pkg::CK_MINUS, cal_pkg::CK_MUL, cal_pkg::CK_DIV: begin
            st_nxt.mode = kmode;
            st_nxt.term = 1'b0;
            st_nxt.entered = 1'b0;
            if (st_r.term) begin
              st_nxt.acc = st_r.ent;
            end else if (st_r.entered) begin
              go = 1'b1;
              st_nxt.wb_acc = 1'b1;
            end
          end
          cal_pkg::CK_EQ, cal_pkg::CK_PCT: begin
            st_nxt.entered = 1'b0;
            go = 1'b1;
            if (st_r.db_key.fn == cal_pkg::CK_PCT && st_r.mode inside {cal_pkg::CM_ADD, cal_pkg::CM_SUB}) begin
              if (!st_r.term) begin
                op = cal_pkg::CM_MUL;
                ydp2 = 1'b1;
              end else begin
                op = cal_pkg::CM_ADD;
                opx = st_r.ent;
                opy = '0;
                xdp2 = 1'b1;
                st_nxt.wb_acc = 1'b1;
                st_nxt.mode = cal_pkg::CM_MUL;
              end
            end else if (st_r.term) begin
              opx = st_r.ent;
              opy = st_r.acc;
              xdp2 = (st_r.db_key.fn == cal_pkg::CK_PCT);
            end else begin
              st_nxt.acc = st_r.ent;
              st_nxt.term = 1'b1;
              ydp2 = (st_r.db_key.fn == cal_pkg::CK_PCT);
            end
          end
          cal_pkg::CK_CLEAR: begin
            st_nxt.entered = 1'b0;
            if (st_r.entry_on) begin
              st_nxt.ent = st_r.acc;
            end else begin
              st_nxt.ent = '0;
              st_nxt.acc = '0;
              st_nxt.mode = cal_pkg::CM_ADD;
              st_nxt.term = 1'b1;
            end
          end
          cal_pkg::CK_MSAVE: st_nxt.mem = st_r.ent;
          cal_pkg::CK_MRECALL: begin
            st_nxt.ent = st_r.mem;
            st_nxt.entered = 1'b1;
          end
          cal_pkg::CK_MPLUS, cal_pkg::CK_MMINUS: begin
            go = 1'b1;
            op = (st_r.db_key.fn == cal_pkg::CK_MPLUS) ? cal_pkg::CM_ADD : cal_pkg::CM_SUB;
            opx = st_r.mem;
            st_nxt.wb_mem = 1'b1;
          end
          default: ;
        endcase
      end
    end
    // Operands are widened to binary with their point counts kept apart
    if (go) begin
      bx = cal_bcd2bin(opx.dig);
      by = cal_bcd2bin(opy.dig);
      dx = {1'b0, opx.dp} + (xdp2 ? cal_pkg::PCT_SHIFT : 5'h0);
      dy = {1'b0, opy.dp} + (ydp2 ? cal_pkg::PCT_SHIFT : 5'h0);
      st_nxt.seq = cal_pkg::SQ_NORM;
      st_nxt.rneg = opx.neg ^ opy.neg;
      unique case (op)
        cal_pkg::CM_ADD, cal_pkg::CM_SUB: begin
          dm = (dx > dy) ? dx : dy;
          sx = $signed({2'b00, bx * cal_pow10(dm - dx)});
          sy = $signed({2'b00, by * cal_pow10(dm - dy)});
          sx = opx.neg ? -sx : sx;
          sy = (opy.neg ^ (op == cal_pkg::CM_SUB)) ? -sy : sy;
          sum = sx + sy;
          st_nxt.rneg = sum[65];
          st_nxt.wrk = sum[65] ? 64'(-sum) : sum[63:0];
          st_nxt.rdp = dm;
        end
        cal_pkg::CM_MUL: begin
          st_nxt.wrk = 64'(bx * by);
          st_nxt.rdp = dx + dy;
        end
        default: begin
          st_nxt.wrk = 64'(bx * cal_pow10(cal_pkg::DIV_EXTRA));
          st_nxt.den = by[26:0];
          st_nxt.rem = '0;
          st_nxt.cnt = '0;
          st_nxt.rdp = dx + cal_pkg::DIV_EXTRA - dy;
          st_nxt.seq = cal_pkg::SQ_DIVIDE;
          if (by == '0) begin
            st_nxt.wrk = '1;
            st_nxt.seq = cal_pkg::SQ_NORM;
          end
        end
      endcase
    end
    // Restoring division, one quotient bit a cycle
    if (st_r.seq == cal_pkg::SQ_DIVIDE) begin
      trial = {st_r.rem, st_r.wrk[63]};
      st_nxt.rem = (trial >= {2'b00, st_r.den}) ? 28'(trial - {2'b00, st_r.den}) : trial[27:0];
      st_nxt.wrk = {st_r.wrk[62:0], trial >= {2'b00, st_r.den}};
      st_nxt.cnt = st_r.cnt + 6'h1;
      if (st_r.cnt == 6'h3F) begin
        st_nxt.seq = cal_pkg::SQ_NORM;
      end
    end
    // Truncate to eight digits, then strip trailing fraction zeros
    if (st_r.seq == cal_pkg::SQ_NORM) begin
      if (st_r.wrk > cal_pkg::MAX_MAG || st_r.rdp > cal_pkg::DP_MAX) begin
        st_nxt.wrk = st_r.wrk / 64'hA;
        if (st_r.rdp != 5'h0) begin
          st_nxt.rdp = st_r.rdp - 5'h1;
        end else begin
          st_nxt.err = 1'b1;
        end
      end else if (st_r.rdp != 5'h0 && st_r.wrk % 64'hA == 64'h0) begin
        st_nxt.wrk = st_r.wrk / 64'hA;
        st_nxt.rdp = st_r.rdp - 5'h1;
      end else begin
        res = {st_r.rneg && st_r.wrk != '0, st_r.rdp[3:0], cal_bin2bcd(st_r.wrk[26:0])};
        st_nxt.seq = cal_pkg::SQ_IDLE;
        if (st_r.wb_mem) begin
          st_nxt.mem = res;
        end else begin
          st_nxt.ent = res;
        end
        if (st_r.wb_acc) begin
          st_nxt.acc = res;
        end
      end
    end
    // Display of the entry register at the current position
    top = cal_top(st_r.ent);
    dval = (st_r.pos < cal_pkg::LAST_POS) ? st_r.ent.dig[4*st_r.pos[2:0]+:4] : 4'h0;
    st_nxt.seg = 8'h00;
    if (st_r.pos <= top && st_r.pos < cal_pkg::LAST_POS) begin
      st_nxt.seg = cal_seven(dval);
    end else if (st_r.ent.neg && st_r.pos == top + 4'h1) begin
      st_nxt.seg = cal_pkg::SEG_MINUS;
    end
    if ((st_r.pos == st_r.ent.dp && st_r.pos < cal_pkg::LAST_POS) || st_r.err ||
        (st_r.pos == cal_pkg::LAST_POS && st_r.mem.dig != '0)) begin
      st_nxt.seg = st_nxt.seg | cal_pkg::SEG_DP;
    end
    st_nxt.strobe = '0;
    if (st_r.tick >= 11'(BLANK_CYC)) begin
      st_nxt.strobe[st_r.pos] = 1'b1;
    end else begin
      st_nxt.seg = 8'h00;
    end
    st_nxt.busy = st_nxt.seq != cal_pkg::SQ_IDLE;
  end

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      st_r <= '0;
      st_r.term <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_digit_strobe = st_r.strobe;
  assign o_segment = st_r.seg;
  assign o_error = st_r.err;
  assign o_busy = st_r.busy;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!rst_q);

  sequence s_busy_start;
    st_r.seq == cal_pkg::SQ_IDLE ##1 st_r.seq != cal_pkg::SQ_IDLE;
  endsequence
  sequence s_idle_again;
    ##[1:150] st_r.seq == cal_pkg::SQ_IDLE;
  endsequence

  a_calc_bound: assert property (s_busy_start |-> s_idle_again) else $error("calculation too long");
  a_power_on_state: assert property ($rose(rst_q) |-> st_r.term && st_r.mode == cal_pkg::CM_ADD && st_r.mem == '0)
    else $error("bad power-on state");
  a_mem_guard: assert property (!(fire && st_r.db_key.fn == cal_pkg::CK_MSAVE) &&
    !(st_r.seq == cal_pkg::SQ_NORM && st_r.wb_mem) |=> $stable(st_r.mem)) else $error("memory disturbed");
  a_term_clear: assert property (fire && !st_r.err && st_r.db_key.fn inside {cal_pkg::CK_PLUS, cal_pkg::CK_MINUS,
    cal_pkg::CK_MUL, cal_pkg::CK_DIV} |=> !st_r.term && st_r.mode == $past(kmode)) else $error("mode or flag");
  a_term_set: assert property (fire && !st_r.err && st_r.db_key.fn == cal_pkg::CK_EQ |=> st_r.term)
    else $error("equals left flag clear");
  a_eq_constant: assert property (fire && !st_r.err && !st_r.term && st_r.db_key.fn == cal_pkg::CK_EQ
    |=> st_r.acc == $past(st_r.ent)) else $error("constant not saved");
  a_entry_limit: assert property (fire && st_r.db_key.fn == cal_pkg::CK_DIGIT && st_r.entry_on &&
    st_r.ent.dig[31:28] != 4'h0 |=> $stable(st_r.ent)) else $error("ninth digit taken");
  a_key_debounced: assert property (fire |-> st_r.db == cal_pkg::DB_PRESS && st_r.seen &&
    st_r.seen_key == st_r.db_key) else $error("key without debounce");
  a_error_points: assert property (st_r.err && st_r.tick == 11'(BLANK_CYC + 1) |=> o_segment[7])
    else $error("error points dark");
endmodule : cal_core

// [cal_keypad.sv]
// Key matrix and display capture model for the calculator core
`timescale 1ns/1ps
module cal_keypad (
  input wire logic i_ref_clk, // Clock
  input wire logic [8:0] i_digit_strobe, // Digit select from core
  input wire logic [7:0] i_segment, // Segments from core
  input wire logic i_press, // Key held closed
  input wire logic [4:0] i_code, // Key code, position*4+return
  output cal_pkg::cal_ret_t o_ret, // Key returns to core
  output logic [8:0][7:0] o_disp // Last segments seen per position
);
  logic [3:0] hit;

  // Open returns are pulled low; a closed key echoes its strobe
  always_comb begin
    hit = '0;
    if (i_press && i_digit_strobe[i_code[4:2]]) begin
      hit[i_code[1:0]] = 1'b1;
    end
    o_ret = {hit[0], hit[1], hit[2], hit[3]};
  end

  always_ff @(posedge i_ref_clk) begin
    for (int p = 0; p < 9; p++) begin
      if (i_digit_strobe[p]) begin
        o_disp[p] <= i_segment;
      end
    end
  end
endmodule : cal_keypad

// [cal_core_tb.sv]
// Self-checking testbench for the calculator core
`timescale 1ns/1ps
module cal_core_tb;
  localparam int WORD = 72;
  localparam logic [4:0] PLUS = 5'h0C;
  localparam logic [4:0] MINUS = 5'h0D;
  localparam logic [4:0] MUL = 5'h0E;
  localparam logic [4:0] EQ = 5'h10;
  localparam logic [4:0] PCT = 5'h11;
  localparam logic [4:0] CLR = 5'h12;
  localparam logic [4:0] MSAVE = 5'h13;
  localparam logic [4:0] MREC = 5'h14;
  logic clk;
  logic rstn;
  logic press;
  logic [4:0] code;
  cal_pkg::cal_ret_t ret;
  logic [8:0] strobe;
  logic [7:0] seg;
  logic err;
  logic busy;
  logic [8:0][7:0] disp;
  int err_count = 0;
  int compares = 0;
  int busy_run = 0;
  int busy_max = 0;

  cal_core #(.DIGIT_CYC(8), .BLANK_CYC(2), .KEY_WORDS(2)) cal_core_i (
    .i_ref_clk(clk), .i_resetn(rstn),
    .i_key_return_one(ret.key_return_one), .i_key_return_two(ret.key_return_two),
    .i_key_return_three(ret.key_return_three), .i_key_return_four(ret.key_return_four),
    .o_digit_strobe(strobe), .o_segment(seg), .o_error(err), .o_busy(busy));

  cal_keypad cal_keypad_i (.i_ref_clk(clk), .i_digit_strobe(strobe), .i_segment(seg),
    .i_press(press), .i_code(code), .o_ret(ret), .o_disp(disp));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    busy_run = (busy === 1'b1) ? busy_run + 1 : 0;
    if (busy_run > busy_max) busy_max = busy_run;
  end

  task automatic final_report;
    $display("mismatches %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: return 7'h3F;
      4'h1: return 7'h06;
      4'h2: return 7'h5B;
      4'h3: return 7'h4F;
      4'h4: return 7'h66;
      4'h5: return 7'h6D;
      4'h6: return 7'h7D;
      4'h7: return 7'h07;
      4'h8: return 7'h7F;
      default: return 7'h6F;
    endcase
  endfunction : seg7

  // Integer results only: point bits are masked out
  task automatic show(input int v);
    logic [62:0] e;
    logic [62:0] g;
    int m;
    int top;
    m = (v < 0) ? -v : v;
    e = '0;
    top = 0;
    for (int p = 0; p < 8; p++) begin
      if (p == 0 || m > 0) begin
        e[p*7 +: 7] = seg7(4'(m % 10));
        top = p;
      end
      m = m / 10;
    end
    if (v < 0) e[(top+1)*7 +: 7] = cal_pkg::SEG_MINUS[6:0];
    for (int p = 0; p < 9; p++) g[p*7 +: 7] = disp[p][6:0];
    chk(64'(g), 64'(e));
  endtask : show

  // Holds a key for cyc cycles, waits out release debounce and the calculation
  task automatic key(input logic [4:0] c, input int cyc = 5 * WORD);
    press <= 1'b1;
    code <= c;
    repeat (cyc) @(posedge clk);
    press <= 1'b0;
    repeat (5 * WORD) @(posedge clk);
    for (int i = 0; i < 200 * WORD && busy !== 1'b0; i++) @(posedge clk);
    chk(64'(busy), 64'h0);
    repeat (WORD + 2) @(posedge clk);
  endtask : key

  task automatic num(input int v);
    if (v >= 100) key(5'(v / 100));
    if (v >= 10) key(5'((v / 10) % 10));
    key(5'(v % 10));
  endtask : num

  task automatic t_reset;
    repeat (2 * WORD) @(posedge clk);
    show(0);
    chk(64'(err), 64'h0);
  endtask : t_reset

  task automatic t_addsub;
    key(CLR);
    num(3);
    key(PLUS);
    num(2);
    key(PLUS);
    show(5);
    key(MINUS);
    show(5);
    num(4);
    key(EQ);
    show(1);
    key(EQ);
    show(-3);
    key(PLUS);
    num(2);
    key(EQ);
    show(-1);
  endtask : t_addsub

  task automatic t_mul;
    key(CLR);
    num(3);
    key(MUL);
    num(4);
    key(EQ);
    show(12);
    key(EQ);
    show(48);
    num(5);
    key(EQ);
    show(20);
  endtask : t_mul

  task automatic t_pct;
    key(CLR);
    num(200);
    key(PLUS);
    num(5);
    key(PCT);
    show(10);
  endtask : t_pct

  task automatic t_bounce;
    key(CLR);
    num(3);
    key(5'h05, 40);
    show(3);
  endtask : t_bounce

  task automatic t_mem;
    key(CLR);
    num(7);
    key(MSAVE);
    chk(64'(disp[8]), 64'(cal_pkg::SEG_DP));
    show(7);
    key(CLR);
    key(CLR);
    show(0);
    key(MREC);
    show(7);
  endtask : t_mem

  task automatic t_ovf;
    key(CLR);
    repeat (9) key(5'h09);
    show(99999999);
    key(PLUS);
    num(1);
    key(PLUS);
    chk(64'(err), 64'h1);
    key(CLR);
    chk(64'(err), 64'h0);
  endtask : t_ovf

  task automatic t_more;
    key(CLR);
    num(8);
    key(5'h0F);
    num(2);
    key(EQ);
    show(4);
    key(5'h15);
    key(MREC);
    show(11);
    key(5'h16);
    chk(64'(disp[8]), 64'h0);
    key(CLR);
    num(500);
    key(PCT);
    show(5);
    key(EQ);
    show(25);
    num(3);
    key(5'h0B);
    show(-3);
    key(EQ);
    show(-15);
  endtask : t_more

  initial begin
    rstn = 1'b0;
    press = 1'b0;
    code = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_addsub();
    t_mul();
    t_pct();
    t_bounce();
    t_mem();
    t_ovf();
    t_more();
    chk(64'(busy_max <= 200 * WORD), 64'h1);
    final_report();
  end

  // Run needs about 55000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule : cal_core_tb
